//--- design/adc_digital_output_interface.sv
// Digital output stage: coding, overdrive clamp, DDR LVDS and CMOS outputs
`timescale 1ns/10ps
`include "adoi_defs.svh"
// Operation
// - Each sample leaves as an 11-bit word with an output clock aligned to it.
// - LVDS or CMOS output is chosen by a serial register bit or, in pin mode, the select pin.
// - In LVDS mode each differential pair except the top one carries two bits of every sample; the top pair carries one.
// - In LVDS mode even bits launch at the output clock fall and odd bits at its rise.
// - In CMOS mode each bit has its own pin and all bits change once per sample.
// - Offset binary or two's complement is chosen by register bit or the select pin.
// - Positive overdrive forces 0x7FF offset binary or 0x3FF two's complement.
// - Negative overdrive forces 0x000 offset binary or 0x400 two's complement.
// - A serial transfer is an 8-bit address followed by 8-bit data.
// - Register contents can be read back on the serial readout output.
module adc_digital_output_interface #(
   parameter int DATA_W = `ADOI_DATA_W,
   parameter int PAIRS  = `ADOI_PAIRS
) (
   input  wire logic              clock,                 // Sample clock, 10 MHz
   input  wire logic              reset_n,               // Asynchronous reset, active low
   input  wire logic [DATA_W-1:0] coreSample,            // Converter word, offset binary
   input  wire logic              overdrivePos,          // Input above positive full scale
   input  wire logic              overdriveNeg,          // Input below negative full scale
   input  wire logic              parallelConfigPin,     // Pin mode selects config source
   input  wire logic [1:0]        format_select_pin,     // Bit1 interface, bit0 coding
   input  wire logic              serialClock,           // Serial port link clock
   input  wire logic              serialEnable_n,        // Serial frame select, active low
   input  wire logic              serialDataIn,          // Serial data in
   output logic                   serial_readout_out,    // Serial readback data
   output logic [PAIRS-1:0]       lvdsDataPos,           // LVDS pairs, true side
   output logic [PAIRS-1:0]       lvdsDataNeg,           // LVDS pairs, complement side
   output logic                   diff_output_clock_pos, // LVDS output clock, true
   output logic                   diffOutputClockNeg,    // LVDS output clock, complement
   output logic [DATA_W-1:0]      cmosData,              // CMOS data pins
   output logic                   cmos_output_clock,     // CMOS output clock
   output logic                   lvdsActive             // High while LVDS is selected
);
   logic [`ADOI_REG_W-1:0] cfgWord;
   logic                   cfgToggle;
   logic                   cfgToggleSync;
   logic                   cfgToggleSeenReg;
   logic [`ADOI_REG_W-1:0] serialCfgReg;
   logic [2:0]             pinSync;
   logic                   pinModeSync;
   logic [1:0]             formatPinSync;
   adoi_pkg::adoi_if_t     ifWanted;
   adoi_pkg::adoi_fmt_t    fmtWanted;
   adoi_pkg::adoi_if_t     ifModeReg;
   adoi_pkg::adoi_fmt_t    fmtModeReg;
   logic                   clkPhaseReg;
   logic                   sampleEdge;
   logic [DATA_W-1:0]      codedWord;
   logic [DATA_W-1:0]      wordReg;
   logic [PAIRS-1:0]       evenBits;
   logic [PAIRS-1:0]       oddBits;

   // serial frames run on their own clock
   adoi_serial_port u_serial (
      .serialClock      (serialClock),
      .reset_n          (reset_n),
      .serialEnable_n   (serialEnable_n),
      .serialDataIn     (serialDataIn),
      .serialReadoutOut (serial_readout_out),
      .cfgWord          (cfgWord),
      .cfgToggle        (cfgToggle)
   );

   // Config word crosses by toggle handshake; it is stable once the toggle lands
   adoi_sync #(
      .WIDTH (1)
   ) u_toggle_sync (
      .clock   (clock),
      .reset_n (reset_n),
      .asyncIn (cfgToggle),
      .syncOut (cfgToggleSync)
   );

   // Pins come from outside the clock domain
   adoi_sync #(
      .WIDTH (3)
   ) u_pin_sync (
      .clock   (clock),
      .reset_n (reset_n),
      .asyncIn ({parallelConfigPin, format_select_pin}),
      .syncOut (pinSync)
   );

   assign pinModeSync   = pinSync[2];
   assign formatPinSync = pinSync[1:0];

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfgToggleSeenReg <= 1'b0;
      end else begin
         cfgToggleSeenReg <= cfgToggleSync;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         serialCfgReg <= `ADOI_CFG_RESET;
      end else if (cfgToggleSync != cfgToggleSeenReg) begin
         serialCfgReg <= cfgWord;
      end
   end

   assign ifWanted = (pinModeSync ? formatPinSync[`ADOI_PIN_LVDS]
                                  : serialCfgReg[`ADOI_CFG_LVDS])
                     ? adoi_pkg::ADOI_IF_LVDS : adoi_pkg::ADOI_IF_CMOS;

   assign fmtWanted = (pinModeSync ? formatPinSync[`ADOI_PIN_TWOS]
                                   : serialCfgReg[`ADOI_CFG_TWOS])
                      ? adoi_pkg::ADOI_FMT_TWOS : adoi_pkg::ADOI_FMT_OFFSET;

   // A new sample is taken on the edge that drops the output clock
   assign sampleEdge = clkPhaseReg;

   // overdrive clamp, positive wins if both flags are set
   always_comb begin
      codedWord = coreSample;
      if (fmtWanted == adoi_pkg::ADOI_FMT_TWOS) begin
         codedWord = coreSample ^ `ADOI_SIGN_FLIP;
      end
      if (overdrivePos) begin
         codedWord = (fmtWanted == adoi_pkg::ADOI_FMT_TWOS) ? `ADOI_TC_POS_FS
                                                            : `ADOI_OB_POS_FS;
      end else if (overdriveNeg) begin
         codedWord = (fmtWanted == adoi_pkg::ADOI_FMT_TWOS) ? `ADOI_TC_NEG_FS
                                                            : `ADOI_OB_NEG_FS;
      end
   end

   // bit 2k goes to pair k at the fall, 2k+1 at the rise
   genvar k;
   generate
      for (k = 0; k < PAIRS; k++) begin : g_pair
         assign evenBits[k] = codedWord[2*k];
         if (2*k+1 < DATA_W) begin : g_odd
            assign oddBits[k] = wordReg[2*k+1];
         end else begin : g_spare
            // Unused odd slot of the top pair stays low
            assign oddBits[k] = 1'b0;
         end
      end
   endgenerate

   // output clock runs at half the sample clock, one sample per period
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         clkPhaseReg <= 1'b0;
      end else begin
         clkPhaseReg <= ~clkPhaseReg;
      end
   end

   // Mode changes only at a sample boundary so no word is split
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ifModeReg  <= adoi_pkg::ADOI_IF_CMOS;
         fmtModeReg <= adoi_pkg::ADOI_FMT_OFFSET;
         lvdsActive <= 1'b0;
      end else if (sampleEdge) begin
         ifModeReg  <= ifWanted;
         fmtModeReg <= fmtWanted;
         lvdsActive <= (ifWanted == adoi_pkg::ADOI_IF_LVDS);
      end
   end

   // word held for the whole output clock period
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wordReg <= '0;
      end else if (sampleEdge) begin
         wordReg <= codedWord;
      end
   end

   // differential clock; idle low on both legs in CMOS mode
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         diff_output_clock_pos <= 1'b0;
         diffOutputClockNeg    <= 1'b0;
      end else if (sampleEdge) begin
         diff_output_clock_pos <= 1'b0;
         diffOutputClockNeg    <= (ifWanted == adoi_pkg::ADOI_IF_LVDS);
      end else if (ifModeReg == adoi_pkg::ADOI_IF_LVDS) begin
         diff_output_clock_pos <= 1'b1;
         diffOutputClockNeg    <= 1'b0;
      end else begin
         diff_output_clock_pos <= 1'b0;
         diffOutputClockNeg    <= 1'b0;
      end
   end

   // two bits per pair: even with the fall, odd with the rise
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lvdsDataPos <= '0;
         lvdsDataNeg <= '0;
      end else if (sampleEdge && ifWanted == adoi_pkg::ADOI_IF_LVDS) begin
         lvdsDataPos <= evenBits;
         lvdsDataNeg <= ~evenBits;
      end else if (!sampleEdge && ifModeReg == adoi_pkg::ADOI_IF_LVDS) begin
         lvdsDataPos <= oddBits;
         lvdsDataNeg <= ~oddBits;
      end else if (sampleEdge) begin
         // Pairs quiet while CMOS is selected
         lvdsDataPos <= '0;
         lvdsDataNeg <= '0;
      end
   end

   // all CMOS pins change together once per sample, clock low
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cmosData <= '0;
      end else if (sampleEdge) begin
         cmosData <= (ifWanted == adoi_pkg::ADOI_IF_CMOS) ? codedWord : '0;
      end
   end

   // rise falls mid-word so the receiver latches stable data
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cmos_output_clock <= 1'b0;
      end else if (sampleEdge) begin
         cmos_output_clock <= 1'b0;
      end else begin
         cmos_output_clock <= (ifModeReg == adoi_pkg::ADOI_IF_CMOS);
      end
   end

   // the high-rate capture clock is outside this block; fmtModeReg marks the
   // coding of the word now on the pins for anyone probing it
   logic unusedFmt;
   assign unusedFmt = (fmtModeReg == adoi_pkg::ADOI_FMT_TWOS);
endmodule

//--- design/adoi_defs.svh
// Constants for the converter digital output stage and its serial port
`ifndef ADOI_DEFS_SVH
`define ADOI_DEFS_SVH

`define ADOI_DATA_W      11
`define ADOI_PAIRS       6
`define ADOI_REG_W       8
`define ADOI_CNT_W       5
`define ADOI_ADDR_LAST   5'h07
`define ADOI_FRAME_LAST  5'h0f
`define ADOI_FRAME_DONE  5'h10
`define ADOI_READ_BIT    7
`define ADOI_REG_CFG     7'h00
`define ADOI_CFG_RESET   8'h00
`define ADOI_CFG_LVDS    1
`define ADOI_CFG_TWOS    0
`define ADOI_PIN_LVDS    1
`define ADOI_PIN_TWOS    0
`define ADOI_OB_POS_FS   11'h7ff
`define ADOI_OB_NEG_FS   11'h000
`define ADOI_TC_POS_FS   11'h3ff
`define ADOI_TC_NEG_FS   11'h400
`define ADOI_SIGN_FLIP   11'h400

`endif

//--- design/adoi_pkg.sv
// Types shared by the output stage and its serial port
package adoi_pkg;
   typedef enum logic {ADOI_IF_CMOS, ADOI_IF_LVDS} adoi_if_t;
   typedef enum logic {ADOI_FMT_OFFSET, ADOI_FMT_TWOS} adoi_fmt_t;
   typedef enum logic [1:0] {ADOI_SER_ADDR, ADOI_SER_DATA, ADOI_SER_DONE} adoi_ser_t;
endpackage

//--- design/adoi_sync.sv
// Two-stage synchroniser for levels entering the sample clock domain
`timescale 1ns/10ps
module adoi_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,    // Destination clock
   input  wire logic             reset_n,  // Asynchronous reset, active low
   input  wire logic [WIDTH-1:0] asyncIn,  // Level from another domain or pin
   output logic      [WIDTH-1:0] syncOut   // Level safe to read
);
   logic [WIDTH-1:0] stage1Reg;

   // First stage feeds the second only
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage1Reg <= '0;
         syncOut   <= '0;
      end else begin
         stage1Reg <= asyncIn;
         syncOut   <= stage1Reg;
      end
   end
endmodule

//--- design/adoi_serial_port.sv
// Serial configuration port: address byte then data byte, with readout
`timescale 1ns/10ps
`include "adoi_defs.svh"
module adoi_serial_port (
   input  wire logic                   serialClock,      // Link clock from the host
   input  wire logic                   reset_n,          // Asynchronous reset, active low
   input  wire logic                   serialEnable_n,   // Frame select, active low
   input  wire logic                   serialDataIn,     // Serial data, MSB first
   output logic                        serialReadoutOut, // Read data back to the host
   output logic [`ADOI_REG_W-1:0]      cfgWord,          // Configuration register
   output logic                        cfgToggle         // Flips on each config write
);
   logic                   frameClear_n;
   logic [`ADOI_CNT_W-1:0] bitCountReg;
   logic [`ADOI_REG_W-2:0] shiftReg;
   logic [`ADOI_REG_W-1:0] addrReg;
   logic [`ADOI_REG_W-1:0] readShiftReg;
   logic [`ADOI_REG_W-1:0] byteNow;
   logic [`ADOI_REG_W-1:0] readValue;
   adoi_pkg::adoi_ser_t    stateReg;

   // The clock stops outside frames, so the frame signal ends each frame
   assign frameClear_n = reset_n & ~serialEnable_n;
   assign byteNow      = {shiftReg, serialDataIn};
   // Unmapped addresses read as zero
   assign readValue    = (byteNow[`ADOI_REG_W-2:0] == `ADOI_REG_CFG) ? cfgWord : '0;

   always_ff @(posedge serialClock or negedge frameClear_n) begin
      if (!frameClear_n) begin
         bitCountReg <= '0;
         shiftReg    <= '0;
         addrReg     <= '0;
         stateReg    <= adoi_pkg::ADOI_SER_ADDR;
      end else begin
         shiftReg <= byteNow[`ADOI_REG_W-2:0];
         if (bitCountReg != `ADOI_FRAME_DONE) begin
            bitCountReg <= bitCountReg + 1'b1;
         end
         unique case (stateReg)
            adoi_pkg::ADOI_SER_ADDR: begin
               if (bitCountReg == `ADOI_ADDR_LAST) begin
                  addrReg  <= byteNow;
                  stateReg <= adoi_pkg::ADOI_SER_DATA;
               end
            end
            adoi_pkg::ADOI_SER_DATA: begin
               if (bitCountReg == `ADOI_FRAME_LAST) begin
                  stateReg <= adoi_pkg::ADOI_SER_DONE;
               end
            end
            adoi_pkg::ADOI_SER_DONE: begin
               stateReg <= adoi_pkg::ADOI_SER_DONE;
            end
         endcase
      end
   end

   // data byte lands at the sixteenth edge
   always_ff @(posedge serialClock or negedge reset_n) begin
      if (!reset_n) begin
         cfgWord   <= `ADOI_CFG_RESET;
         cfgToggle <= 1'b0;
      end else if (!serialEnable_n && stateReg == adoi_pkg::ADOI_SER_DATA
                   && bitCountReg == `ADOI_FRAME_LAST && !addrReg[`ADOI_READ_BIT]
                   && addrReg[`ADOI_REG_W-2:0] == `ADOI_REG_CFG) begin
         cfgWord   <= byteNow;
         cfgToggle <= ~cfgToggle;
      end
   end

   // readout shifts MSB first during the data byte
   always_ff @(posedge serialClock or negedge frameClear_n) begin
      if (!frameClear_n) begin
         readShiftReg     <= '0;
         serialReadoutOut <= 1'b0;
      end else if (stateReg == adoi_pkg::ADOI_SER_ADDR && bitCountReg == `ADOI_ADDR_LAST) begin
         readShiftReg     <= byteNow[`ADOI_READ_BIT] ? readValue : '0;
         serialReadoutOut <= byteNow[`ADOI_READ_BIT] & readValue[`ADOI_REG_W-1];
      end else if (stateReg == adoi_pkg::ADOI_SER_DATA) begin
         readShiftReg     <= {readShiftReg[`ADOI_REG_W-2:0], 1'b0};
         serialReadoutOut <= readShiftReg[`ADOI_REG_W-2];
      end else begin
         serialReadoutOut <= 1'b0;
      end
   end
endmodule

//--- verification/adoi_out_chk.sv
// Pin-level checks on the converter output stage
`timescale 1ns/10ps
module adoi_out_chk #(
   parameter int DATA_W = 11,
   parameter int PAIRS  = 6
) (
   input wire logic              clock,                 // Sample clock
   input wire logic              reset_n,               // Reset, active low
   input wire logic              overdrivePos,          // Positive overdrive
   input wire logic              overdriveNeg,          // Negative overdrive
   input wire logic              parallelConfigPin,     // Pin config mode
   input wire logic [1:0]        format_select_pin,     // Pin format select
   input wire logic [PAIRS-1:0]  lvdsDataPos,           // LVDS true side
   input wire logic [PAIRS-1:0]  lvdsDataNeg,           // LVDS complement
   input wire logic              diff_output_clock_pos, // LVDS clock true
   input wire logic              diffOutputClockNeg,    // LVDS clock complement
   input wire logic [DATA_W-1:0] cmosData,              // CMOS data
   input wire logic              cmos_output_clock,     // CMOS clock
   input wire logic              lvdsActive             // LVDS selected
);
   logic [2:0] runCnt;
   logic [3:0] modeHist;
   logic       lvdsSteady;
   logic       cmosSteady;

   // Mode history keeps the checks off the cycles where the interface swaps
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         runCnt   <= 3'h0;
         modeHist <= 4'h0;
      end else begin
         runCnt   <= (runCnt == 3'h7) ? runCnt : runCnt + 3'h1;
         modeHist <= {modeHist[2:0], lvdsActive};
      end
   end
   assign lvdsSteady = lvdsActive && (&modeHist);
   assign cmosSteady = !lvdsActive && !(|modeHist);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   a_lvds_cmos_quiet: assert property (lvdsSteady |-> cmosData == '0 && !cmos_output_clock)
      else $error("CMOS pins active in LVDS mode");
   a_pair_compl: assert property (lvdsSteady |-> lvdsDataNeg == ~lvdsDataPos
      && diffOutputClockNeg != diff_output_clock_pos)
      else $error("LVDS pair sides not complementary");
   a_lvds_clk_toggle: assert property (lvdsSteady
      |-> diff_output_clock_pos != $past(diff_output_clock_pos))
      else $error("LVDS clock missed a half cycle");
   a_top_slot_odd: assert property (lvdsSteady && diff_output_clock_pos
      |-> !lvdsDataPos[PAIRS-1])
      else $error("Unused top odd slot not zero");
   a_cmos_lvds_quiet: assert property (cmosSteady |-> lvdsDataPos == '0
      && lvdsDataNeg == '0 && !diff_output_clock_pos && !diffOutputClockNeg)
      else $error("LVDS pins active in CMOS mode");
   a_cmos_clk_toggle: assert property (cmosSteady && runCnt > 3'h2
      |-> cmos_output_clock != $past(cmos_output_clock))
      else $error("CMOS clock missed a half cycle");
   a_cmos_data_edge: assert property (cmosSteady && $changed(cmosData) |-> !cmos_output_clock)
      else $error("CMOS data moved at clock rise");
   a_pos_fullscale: assert property (cmosSteady && parallelConfigPin && runCnt == 3'h7
      && $past(parallelConfigPin, 6) && $past(format_select_pin, 6) == format_select_pin
      && cmos_output_clock && overdrivePos
      |=> cmosData == ($past(format_select_pin[0]) ? 11'h3ff : 11'h7ff))
      else $error("Positive overdrive code wrong");
   a_neg_fullscale: assert property (cmosSteady && parallelConfigPin && runCnt == 3'h7
      && $past(parallelConfigPin, 6) && $past(format_select_pin, 6) == format_select_pin
      && cmos_output_clock && overdriveNeg && !overdrivePos
      |=> cmosData == ($past(format_select_pin[0]) ? 11'h400 : 11'h000))
      else $error("Negative overdrive code wrong");
endmodule

//--- verification/adoi_rx_model.sv
// Capture receiver: takes each word from the CMOS or DDR LVDS pins
`timescale 1ns/10ps
module adoi_rx_model (
   input wire logic [5:0]  lvdsDataPos,           // LVDS pairs
   input wire logic        diff_output_clock_pos, // LVDS clock
   input wire logic [10:0] cmosData,              // CMOS pins
   input wire logic        cmos_output_clock,     // CMOS clock
   output logic [10:0]     rxWord,                // Last word taken
   output logic            rxLvds,                // Word came over LVDS
   output int              rxCount                // Words taken
);
   logic [5:0] evenBits;

   initial rxCount = 0;
   always @(negedge diff_output_clock_pos) begin
      #20;
      evenBits = lvdsDataPos;
   end
   always @(posedge diff_output_clock_pos) begin
      #20;
      for (int k = 0; k < 11; k++) begin
         rxWord[k] = k[0] ? lvdsDataPos[k / 2] : evenBits[k / 2];
      end
      rxLvds = 1'b1;
      rxCount++;
   end
   // rate far below 150 MSPS, so output clock rise
   always @(posedge cmos_output_clock) begin
      rxWord = cmosData;
      rxLvds = 1'b0;
      rxCount++;
   end
endmodule

//--- verification/adc_digital_output_interface_test.sv
// Self-checking bench for the converter output stage
`timescale 1ns/10ps
module adc_digital_output_interface_test;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [10:0] coreSample = 11'h000;
   logic        overdrivePos = 1'b0;
   logic        overdriveNeg = 1'b0;
   logic        parallelConfigPin = 1'b0;
   logic [1:0]  format_select_pin = 2'h0;
   logic        serialClock = 1'b0;
   logic        serialEnable_n = 1'b1;
   logic        serialDataIn = 1'b0;
   logic        serial_readout_out, diff_output_clock_pos, diffOutputClockNeg;
   logic        cmos_output_clock, lvdsActive, rxLvds, phase, expLvds, expTwos;
   logic        checking = 1'b0;
   logic [5:0]  lvdsDataPos, lvdsDataNeg;
   logic [10:0] cmosData, rxWord;
   logic [10:0] expQ[$];
   logic [7:0]  rd;
   int          rxCount, num_errors = 0, n_tests = 0;

   adc_digital_output_interface uut (.*);
   adoi_rx_model rx (.*);

   always #50 clock = ~clock;

   function automatic logic [10:0] code(input logic [10:0] s, input logic p, input logic n);
      if (p) return expTwos ? 11'h3ff : 11'h7ff;
      if (n) return expTwos ? 11'h400 : 11'h000;
      return expTwos ? s ^ 11'h400 : s;
   endfunction

   task automatic chkWord(input logic [10:0] got, input logic [10:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: mode flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: readback %h expected %h", $time, got, exp);
      end
   endtask

   // Address byte then data byte, MSB first; link clock idles low between frames
   task automatic frame(input logic [7:0] addr, input logic [7:0] data);
      logic [15:0] bits;
      bits = {addr, data};
      #7 serialEnable_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         serialDataIn = bits[15 - i];
         #24 serialClock = 1'b1;
         #24 serialClock = 1'b0;
         if (i >= 7 && i <= 14) rd[14 - i] = serial_readout_out;
      end
      #24 serialEnable_n = 1'b1;
      serialDataIn = ~serialDataIn;
      #500;
   endtask

   task automatic runMode(input int m);
      int startCount;
      repeat (8) @(negedge clock);
      expLvds = m[1];
      expTwos = m[0];
      repeat (4) @(negedge clock);
      checking = 1'b1;
      startCount = rxCount;
      chkBit(lvdsActive, expLvds);
      repeat (60) @(negedge clock);
      checking = 1'b0;
      // One word per two sample clocks, so a silent receiver cannot pass
      chkWord(11'(rxCount - startCount), 11'h01e);
   endtask

   task automatic results();
      $display("Compares %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Reference: one sample on every second edge, the first at the second edge after reset
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phase = 1'b0;
      end else begin
         if (phase) expQ.push_back(code(coreSample, overdrivePos, overdriveNeg));
         phase = ~phase;
      end
   end

   // Only the newest sample matters when a word is captured
   always @(rxCount) begin
      while (expQ.size() > 1) void'(expQ.pop_front());
      if (checking && expQ.size() == 1) begin
         chkWord(rxWord, expQ.pop_front());
         chkBit(rxLvds, expLvds);
      end
   end

   initial begin
      void'($urandom(35));
      forever begin
         @(negedge clock);
         coreSample   <= 11'($urandom);
         overdrivePos <= ($urandom % 8) == 0;
         overdriveNeg <= ($urandom % 8) == 0;
      end
   end

   initial begin
      #400000;
      num_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      results();
   end

   initial begin
      repeat (2) @(posedge clock);
      chkWord(cmosData, 11'h000);
      chkBit(lvdsActive, 1'b0);
      @(negedge clock) reset_n = 1'b1;
      frame(8'h80, 8'h00);
      chkByte(rd, 8'h00);
      for (int m = 0; m < 4; m++) begin
         frame(8'h00, 8'(m));
         frame(8'h05, 8'(m ^ 3));
         frame(8'h85, 8'h5a);
         chkByte(rd, 8'h00);
         frame(8'h80, 8'h00);
         chkByte(rd, 8'(m));
         runMode(m);
         $display("Register config %0d done", m);
      end
      parallelConfigPin = 1'b1;
      for (int m = 0; m < 4; m++) begin
         format_select_pin = 2'(m);
         runMode(m);
         $display("Pin config %0d done", m);
      end
      results();
   end
endmodule

bind adc_digital_output_interface adoi_out_chk #(
   .DATA_W (DATA_W),
   .PAIRS  (PAIRS)
) chk (
   .clock                 (clock),
   .reset_n               (reset_n),
   .overdrivePos          (overdrivePos),
   .overdriveNeg          (overdriveNeg),
   .parallelConfigPin     (parallelConfigPin),
   .format_select_pin     (format_select_pin),
   .lvdsDataPos           (lvdsDataPos),
   .lvdsDataNeg           (lvdsDataNeg),
   .diff_output_clock_pos (diff_output_clock_pos),
   .diffOutputClockNeg    (diffOutputClockNeg),
   .cmosData              (cmosData),
   .cmos_output_clock     (cmos_output_clock),
   .lvdsActive            (lvdsActive)
);
